//--- act_pkg.sv
// Constants, register map and carrier types for the conversion timing sequencer.
// Assumes one 50 MHz system clock and a synchronous active-low reset.
package act_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_MODE    = 8'h04;
  localparam logic [7:0]  OFS_STATE   = 8'h08;
  localparam logic [7:0]  OFS_INT_ST  = 8'h0c;
  localparam logic [7:0]  OFS_INT_CLR = 8'h10;
  localparam logic [7:0]  OFS_INT_EN  = 8'h14;

  localparam int          CTRL_START_BIT = 0;
  localparam int          CTRL_EN_BIT    = 1;
  localparam int          STATE_PH_LSB   = 0;
  localparam int          STATE_CNT_LSB  = 8;
  localparam int          NUM_EV         = 2;
  localparam int          EV_CONV_END    = 0;
  localparam int          EV_TRIG_LOST   = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Mode fields.
  localparam logic [2:0]  RATIO_DIV32 = 3'h0;
  localparam logic [2:0]  RATIO_DIV16 = 3'h1;
  localparam logic [2:0]  RATIO_UNDIV = 3'h5;
  localparam logic [1:0]  VM_NORMAL1  = 2'h0;
  localparam logic [1:0]  VM_LOW1     = 2'h2;

  typedef struct packed {
    logic       seq;
    logic       hw;
    logic       wait_en;
    logic       low_speed_select;
    logic [1:0] voltage_mode_field;
    logic [2:0] clock_ratio_field;
  } act_mode_t;

  localparam int          MODE_W      = $bits(act_mode_t);

  ////////////////////////////////////////////////////////////////////////////
  // Divider and cycle counts.
  localparam int          DIV_W       = 6;
  localparam logic [5:0]  DIV_N32     = 6'h20;
  localparam logic [5:0]  DIV_N16     = 6'h10;
  localparam logic [5:0]  DIV_N1      = 6'h01;

  localparam int          CNT_W             = 8;
  localparam logic [7:0]  CNT_SDLY          = 8'h01;
  localparam logic [7:0]  CNT_STAB_DIV      = 8'h04;
  localparam logic [7:0]  CNT_STAB_UNDIV    = 8'h06;
  localparam logic [7:0]  CNT_CONV_NORM_DIV = 8'h40;
  localparam logic [7:0]  CNT_CONV_NORM_UND = 8'hb5;
  localparam logic [7:0]  CNT_CONV_LV_DIV   = 8'h50;
  localparam logic [7:0]  CNT_CONV_LV_UND   = 8'h6b;
  localparam logic [7:0]  CNT_INTD_WAIT     = 8'h04;
  localparam logic [7:0]  CNT_INTD_NOWAIT   = 8'h01;
  localparam logic [7:0]  CNT_SEQ_SHORTEN   = 8'h03;
  localparam logic [7:0]  CNT_START_DIV32   = 8'h1f;
  localparam logic [7:0]  CNT_START_DIV16   = 8'h0f;
  localparam logic [7:0]  CNT_START_SHORT   = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer phases.
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_START = 3'b001,
    PH_STAB  = 3'b010,
    PH_SDLY  = 3'b011,
    PH_CONV  = 3'b100,
    PH_INTD  = 3'b101
  } act_phase_t;

endpackage

//--- act_fad_div.sv
// Conversion clock divider: one-cycle enable pulse every div_n system clocks.
// Assumes div_n is at least one and stays stable while run is high.
`timescale 1ns/1ns
module act_fad_div
  import act_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div_n,
  output logic                  tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } act_div_st_t;

  act_div_st_t q;
  act_div_st_t d;

  ////////////////////////////////////////////////////////////////////////////
  // The count restarts whenever run drops, so each phase begins aligned.
  always_comb begin
    d = q;
    if (!run) begin
      d.cnt  = '0;
      d.tick = 1'b0;
    end else if (q.cnt == div_n - DIV_N1) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt  = q.cnt + DIV_N1;
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

//--- act_seq.sv
// Conversion timing sequencer with register port and conversion-end interrupt.
// Assumes synchronous hardware trigger pulses and a one-cycle register bus.
//
// Summary of operation
// - Low-voltage divided: 1 delay, 80 convert, 1 interrupt.
// - Low-voltage undivided: 1 delay, 107 convert, 1 interrupt.
// - Normal wait divided: 4 stabilise, 64 convert, 4 interrupt.
// - Normal wait undivided: 6 stabilise, 181 convert, 4.
// - Ratio 000 is /32, 001 /16, 101 undivided.
// - Voltage field 00 normal, 10 low-voltage.
// - Sequential wait mode shortens interrupt delay by three.
// - Later hardware-trigger sequential conversions skip start and stabilise.
// - Stabilise starts at trigger or start-bit write; here it starts one system clock later, after the one-clock start phase.
// - Start time precedes the first conversion.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
module act_seq
  import act_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              hw_trig,
  output logic                   conv_end,
  output logic                   converting,
  output logic                   busy,
  output logic                   irq
);

  typedef struct packed {
    act_phase_t        phase;
    logic [CNT_W-1:0]  cnt;
    logic              start;
    logic              enable;
    act_mode_t         mode;
    logic [NUM_EV-1:0] int_st;
    logic [NUM_EV-1:0] int_en;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              end_pulse;
    logic              busy;
    logic              converting;
  } act_st_t;

  act_st_t           q;
  act_st_t           d;
  logic              fad_tick;
  logic              fad_run;
  logic [DIV_W-1:0]  div_n;
  logic [CNT_W-1:0]  tgt;
  logic              undiv;

  ////////////////////////////////////////////////////////////////////////////
  // Phase lengths: system clocks in the start phase, conversion clocks after.
  function automatic logic [CNT_W-1:0] phase_len(input act_phase_t ph, input act_mode_t m);
    logic ud;
    logic lv;
    ud = (m.clock_ratio_field == RATIO_UNDIV);
    lv = (m.voltage_mode_field == VM_LOW1);
    case (ph)
      PH_START: begin
        if (m.wait_en || ud) begin
          phase_len = CNT_START_SHORT;
        end else if (m.clock_ratio_field == RATIO_DIV16) begin
          phase_len = CNT_START_DIV16;
        end else begin
          phase_len = CNT_START_DIV32;
        end
      end
      PH_STAB: phase_len = ud ? CNT_STAB_UNDIV : CNT_STAB_DIV;
      PH_SDLY: phase_len = CNT_SDLY;
      PH_CONV: begin
        if (lv) begin
          phase_len = ud ? CNT_CONV_LV_UND : CNT_CONV_LV_DIV;
        end else begin
          phase_len = ud ? CNT_CONV_NORM_UND : CNT_CONV_NORM_DIV;
        end
      end
      PH_INTD: begin
        if (!m.wait_en) begin
          phase_len = CNT_INTD_NOWAIT;
        end else if (m.seq) begin
          phase_len = CNT_INTD_WAIT - CNT_SEQ_SHORTEN;
        end else begin
          phase_len = CNT_INTD_WAIT;
        end
      end
      default: phase_len = CNT_SDLY;
    endcase
  endfunction

  assign undiv   = (q.mode.clock_ratio_field == RATIO_UNDIV);
  assign tgt     = phase_len(q.phase, q.mode);
  assign fad_run = (q.phase != PH_IDLE) && (q.phase != PH_START);
  always_comb begin
    case (q.mode.clock_ratio_field)
      RATIO_DIV32: div_n = DIV_N32;
      RATIO_DIV16: div_n = DIV_N16;
      default:     div_n = DIV_N1;
    endcase
  end

  act_fad_div u_div (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (fad_run),
    .div_n (div_n),
    .tick  (fad_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register port, sequencer and interrupt logic.
  always_comb begin
    logic              wr_ctrl;
    logic              go;
    logic              step;
    logic              done;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;
    wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
    step      = 1'b0;
    done      = 1'b0;
    d         = q;
    ev        = '0;
    clr       = '0;
    go        = 1'b0;
    d.rdata   = '0;
    d.end_pulse = 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: begin
          d.rdata[CTRL_START_BIT] = q.start;
          d.rdata[CTRL_EN_BIT]    = q.enable;
        end
        OFS_MODE:   d.rdata[MODE_W-1:0] = q.mode;
        OFS_STATE: begin
          d.rdata[STATE_PH_LSB +: 3]      = q.phase;
          d.rdata[STATE_CNT_LSB +: CNT_W] = q.cnt;
        end
        OFS_INT_ST: d.rdata[NUM_EV-1:0] = q.int_st;
        OFS_INT_EN: d.rdata[NUM_EV-1:0] = q.int_en;
        default:    d.rdata = '0;
      endcase
    end
    if (reg_wr && (reg_addr == OFS_MODE) && !q.start && !q.enable) begin
      d.mode = act_mode_t'(reg_wdata[MODE_W-1:0]);
    end
    if (reg_wr && (reg_addr == OFS_INT_EN)) begin
      d.int_en = reg_wdata[NUM_EV-1:0];
    end
    if (reg_wr && (reg_addr == OFS_INT_CLR)) begin
      clr = reg_wdata[NUM_EV-1:0];
    end
    if (wr_ctrl) begin
      d.enable = reg_wdata[CTRL_EN_BIT];
      if (!reg_wdata[CTRL_START_BIT]) begin
        d.start = 1'b0;
      end else if (!(q.mode.hw && q.mode.wait_en) && !q.start) begin
        d.start = 1'b1;
        go      = !q.mode.hw;
      end
    end
    if (q.mode.hw && hw_trig && d.enable) begin
      if (q.phase == PH_IDLE) begin
        d.start = 1'b1;
        go      = 1'b1;
      end else begin
        ev[EV_TRIG_LOST] = 1'b1;
      end
    end
    step = (q.phase == PH_START) || fad_tick;
    done = step && (q.cnt == tgt - CNT_SDLY);
    if (step && !done) begin
      d.cnt = q.cnt + CNT_SDLY;
    end
    if (done) begin
      d.cnt = '0;
      case (q.phase)
        PH_START: d.phase = q.mode.wait_en ? PH_STAB : PH_SDLY;
        PH_STAB:  d.phase = PH_CONV;
        PH_SDLY:  d.phase = PH_CONV;
        PH_CONV:  d.phase = PH_INTD;
        PH_INTD: begin
          d.end_pulse      = 1'b1;
          ev[EV_CONV_END]  = 1'b1;
          if (q.mode.seq && d.start) begin
            d.phase = q.mode.hw ? PH_CONV : PH_START;
          end else begin
            d.phase = PH_IDLE;
            if (q.mode.wait_en || !q.mode.hw) begin
              d.start = 1'b0;
            end
          end
        end
        default:  d.phase = PH_IDLE;
      endcase
    end
    if (go && (q.phase == PH_IDLE)) begin
      d.phase = PH_START;
      d.cnt   = '0;
    end
    if (!d.start && (q.phase != PH_IDLE)) begin
      d.phase = PH_IDLE;
      d.cnt   = '0;
    end
    if (!d.enable) begin
      d.start = 1'b0;
      d.phase = PH_IDLE;
      d.cnt   = '0;
    end
    d.int_st     = (q.int_st & ~clr) | ev;
    d.irq        = |(d.int_st & d.int_en);
    d.busy       = (d.phase != PH_IDLE);
    d.converting = (d.phase == PH_CONV);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata  = q.rdata;
  assign conv_end   = q.end_pulse;
  assign converting = q.converting;
  assign busy       = q.busy;
  assign irq        = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on phase lengths, divider rate and sequencing.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_lv_div_lengths: assert property (
    (q.phase == PH_CONV && q.mode.voltage_mode_field == VM_LOW1 && !undiv) |-> (tgt == 8'h50)
  ) else $error("low-voltage divided conversion length wrong");

  a_lv_undiv_conv: assert property (
    (q.phase == PH_CONV && q.mode.voltage_mode_field == VM_LOW1 && undiv) |-> (tgt == 8'h6b)
  ) else $error("low-voltage undivided conversion length wrong");

  a_stab_div_len: assert property (
    (q.phase == PH_STAB && !undiv && fad_tick && q.cnt == 8'h03) |=> (q.phase == PH_CONV)
  ) else $error("divided stabilisation did not last four cycles");

  a_norm_undiv_conv: assert property (
    (q.phase == PH_CONV && q.mode.voltage_mode_field == VM_NORMAL1 && undiv) |-> (tgt == 8'hb5)
  ) else $error("normal undivided conversion length wrong");

  a_div16_gap: assert property (
    (fad_tick && fad_run && q.mode.clock_ratio_field == RATIO_DIV16) |=> !fad_tick [*8]
  ) else $error("divide-by-16 tick came too early");

  a_undiv_rate: assert property (
    (q.phase == PH_CONV && undiv) |-> fad_tick
  ) else $error("undivided conversion clock missed a cycle");

  a_norm_div_conv: assert property (
    (q.phase == PH_CONV && q.mode.voltage_mode_field == VM_NORMAL1 && !undiv) |-> (tgt == 8'h40)
  ) else $error("normal divided conversion length wrong");

  a_seq_intd_short: assert property (
    (q.phase == PH_INTD && q.mode.wait_en && q.mode.seq) |-> (tgt == 8'h01)
  ) else $error("sequential interrupt delay not shortened");

  a_hw_seq_skip: assert property (
    (q.phase == PH_INTD && q.mode.seq && q.mode.hw && q.start && q.enable && fad_tick
     && q.cnt == tgt - 8'h01 && !reg_wr) |=> (q.phase == PH_CONV)
  ) else $error("hardware sequential repeat did not skip ahead");

  a_trig_start: assert property (
    (q.phase == PH_IDLE && q.enable && q.mode.hw && hw_trig && !reg_wr) |=> (q.phase == PH_START && q.start)
  ) else $error("hardware trigger did not start the sequence");

  a_wait_start_one: assert property (
    (q.phase == PH_START && q.mode.wait_en && q.start && q.enable && !reg_wr) |=> (q.phase == PH_STAB)
  ) else $error("wait-mode start time was not one cycle");

  a_start_div32: assert property (
    (q.phase == PH_START && !q.mode.wait_en && q.mode.clock_ratio_field == RATIO_DIV32) |-> (tgt == 8'h1f)
  ) else $error("no-wait start time at divide-by-32 wrong");

  a_end_single: assert property (
    conv_end |=> !conv_end
  ) else $error("conversion end pulse longer than one cycle");

  a_disabled_idle: assert property (
    (!q.enable) |-> (q.phase == PH_IDLE && q.cnt == 8'h00 && !busy)
  ) else $error("counters active while converter disabled");

  c_seq_end: cover property (conv_end && q.mode.seq && q.mode.hw);
  c_undiv_end: cover property (conv_end && undiv && q.mode.wait_en);
  c_trig_lost: cover property (q.int_st[EV_TRIG_LOST]);
  c_lv_end: cover property (conv_end && q.mode.voltage_mode_field == VM_LOW1);

endmodule

//--- act_seq_tb.sv
// Self-checking testbench for the conversion timing sequencer.
// Assumes the act_seq register map and phase timing described in the package.
`timescale 1ns/1ns
module tb
  import act_pkg::*;
;
  typedef struct {
    logic [8:0] mode;
    int         n;
    int         s;
    int         pre;
    int         conv;
    int         intd;
  } act_row_t;

  logic              clk;
  logic              rst_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              hw_trig;
  logic              conv_end;
  logic              converting;
  logic              busy;
  logic              irq;
  logic [31:0]       d;
  int                failures;
  int                samples_checked;
  int                rise;
  int                width;
  int                tail;

  // Mode word, divide ratio, start clocks, lead ticks, convert ticks, end delay ticks.
  act_row_t rows [7] = '{
    '{9'h000, 32, 31, 1, 64, 1},
    '{9'h010, 32, 31, 1, 80, 1},
    '{9'h011, 16, 15, 1, 80, 1},
    '{9'h035, 1, 1, 1, 107, 1},
    '{9'h040, 32, 1, 4, 64, 4},
    '{9'h065, 1, 1, 6, 181, 4},
    '{9'h151, 16, 1, 4, 80, 1}
  };

  act_seq i_dut (
    .clk        (clk),
    .rst_b      (rst_b),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .hw_trig    (hw_trig),
    .conv_end   (conv_end),
    .converting (converting),
    .busy       (busy),
    .irq        (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tasks.
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Times the converting window from the launching edge, and the end pulse from the fall of converting.
  task automatic measure(output int r, output int w, output int tl);
    int t;
    int fall;
    t    = 0;
    r    = -1;
    fall = -1;
    tl   = -1;
    #1;
    if (converting === 1'b1) r = 0;
    while (t < 20000 && tl < 0) begin
      @(posedge clk);
      #1;
      t++;
      if (converting === 1'b1 && r < 0) r = t;
      if (converting === 1'b0 && r >= 0 && fall < 0) fall = t;
      if (conv_end === 1'b1) tl = t - fall;
    end
    w = fall - r;
    if (tl < 0) begin
      failures++;
      $display("CHECK FAILED conversion end expected 1 seen 0");
      summarize();
    end
  endtask

  task automatic pulse_trig();
    @(posedge clk);
    hw_trig <= 1'b1;
    @(posedge clk);
    hw_trig <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    failures        = 0;
    samples_checked = 0;
    rst_b     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    hw_trig   = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus_rd(OFS_CTRL, d);
    chk("ctrl reset", d, 32'h0);
    bus_rd(OFS_MODE, d);
    chk("mode reset", d, 32'h0);
    bus_rd(8'h1c, d);
    chk("unmapped read", d, 32'h0);
    chk("irq reset", 32'(irq), 32'h0);
    bus_wr(OFS_INT_EN, 32'h1);
    bus_rd(OFS_INT_EN, d);
    chk("int enable readback", d, 32'h1);
    foreach (rows[i]) begin
      bus_wr(OFS_CTRL, 32'h0);
      repeat (10) @(posedge clk);
      bus_wr(OFS_MODE, 32'(rows[i].mode));
      bus_rd(OFS_MODE, d);
      chk("mode readback", d, 32'(rows[i].mode));
      bus_wr(OFS_CTRL, 32'h3);
      measure(rise, width, tail);
      chk("lead time", 32'(rise), 32'(1 + rows[i].s + rows[i].pre * rows[i].n));
      chk("convert time", 32'(width), 32'(rows[i].conv * rows[i].n));
      chk("end delay", 32'(tail), 32'(rows[i].intd * rows[i].n));
      chk("irq at end", 32'(irq), 32'h1);
      @(posedge clk);
      #1;
      chk("end pulse width", 32'(conv_end), 32'h0);
      bus_rd(OFS_INT_ST, d);
      chk("end status", d, 32'h1);
      bus_wr(OFS_INT_CLR, 32'h1);
      #1;
      chk("irq cleared", 32'(irq), 32'h0);
    end
    // Hardware trigger, sequential, stabilisation wait, undivided clock.
    bus_wr(OFS_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    bus_wr(OFS_MODE, 32'h1e5);
    bus_wr(OFS_CTRL, 32'h2);
    pulse_trig();
    measure(rise, width, tail);
    chk("hw lead time", 32'(rise), 32'h8);
    chk("hw end delay", 32'(tail), 32'h1);
    measure(rise, width, tail);
    chk("repeat skips lead", 32'(rise <= 2), 32'h1);
    chk("repeat convert", 32'(width), 32'd181);
    bus_rd(OFS_STATE, d);
    chk("state phase", d & 32'h7, 32'(PH_CONV));
    bus_wr(OFS_INT_CLR, 32'h3);
    pulse_trig();
    bus_rd(OFS_INT_ST, d);
    chk("trigger while busy", d, 32'h2);
    bus_wr(OFS_MODE, 32'h0);
    bus_rd(OFS_MODE, d);
    chk("mode locked", d, 32'h1e5);
    bus_wr(OFS_CTRL, 32'h0);
    @(posedge clk);
    #1;
    chk("busy after disable", 32'(busy), 32'h0);
    chk("converting after disable", 32'(converting), 32'h0);
    bus_rd(OFS_STATE, d);
    chk("state held", d, 32'h0);
    // Hardware trigger, no-wait one-shot, low-voltage, undivided clock.
    repeat (10) @(posedge clk);
    bus_wr(OFS_MODE, 32'h0b5);
    bus_wr(OFS_CTRL, 32'h2);
    pulse_trig();
    measure(rise, width, tail);
    chk("hw no-wait lead", 32'(rise), 32'h3);
    chk("hw no-wait convert", 32'(width), 32'd107);
    chk("hw no-wait end delay", 32'(tail), 32'h1);
    bus_rd(OFS_CTRL, d);
    chk("hw start kept", d, 32'h3);
    summarize();
  end
endmodule
